/* rtl/tfr_pkg.sv */
// Purpose: constants and carriers for the task file register block
// Assumes: one clock, register offsets as decoded on the host pins
// Notes: status and error bit positions named once here
package tfr_pkg;
   // register offsets (index on the host address lines)
   localparam logic [3:0] OFS_DATA = 4'h0;
   localparam logic [3:0] OFS_ERR = 4'h1;
   localparam logic [3:0] OFS_COUNT = 4'h2;
   localparam logic [3:0] OFS_ADDR_LO = 4'h3;
   localparam logic [3:0] OFS_ADDR_MID = 4'h4;
   localparam logic [3:0] OFS_ADDR_HI = 4'h5;
   localparam logic [3:0] OFS_UNIT = 4'h6;
   localparam logic [3:0] OFS_STATUS = 4'h7;
   localparam logic [3:0] OFS_DUP_EVEN = 4'h8;
   localparam logic [3:0] OFS_DUP_ODD = 4'h9;
   localparam logic [3:0] OFS_DUP_ERR = 4'hD;
   localparam logic [3:0] OFS_ALT = 4'hE;
   localparam logic [3:0] OFS_NONE = 4'hF;
   // count value that a zero in the register stands for
   localparam logic [8:0] COUNT_256 = 9'h100;
   // error cause bit positions
   localparam int ERR_BBK = 7;
   localparam int ERR_UNC = 6;
   localparam int ERR_SECTOR_NOT_FOUND_FLAG = 4;
   localparam int ERR_ABORTED_FLAG = 2;
   localparam int ERR_GEN = 0;
   // status bit positions
   localparam int ST_BUSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DWF = 5;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_CORRECTED_FLAG = 2;
   localparam int ST_ERR = 0;
   // unit/head field positions
   localparam int UH_LBA = 6;
   localparam int UH_UNIT = 4;
   // reset values
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [7:0] UNIT_RST = 8'hA0;
   localparam logic [7:0] COUNT_ONE = 8'h01;
   // bus access modes
   typedef enum logic [1:0] {
      TFR_MODE_MEM,
      TFR_MODE_IO,
      TFR_MODE_IDE
   } tfr_mode_e;
   // error events raised by the media engine, one-cycle pulses
   typedef struct packed {
      logic bad_block_or_crc;
      logic uncorrectable;
      logic sector_not_found;
      logic aborted;
      logic general_error;
   } tfr_err_ev_s;
   // engine status levels and events
   typedef struct packed {
      logic busy;
      logic ready;
      logic write_fault;
      logic seek_complete;
      logic xfer_req;
      logic corrected;
   } tfr_stat_s;
endpackage : tfr_pkg

/* rtl/tfr_task_file.sv */
// Purpose: host visible task file registers of a flash storage card
// Assumes: host pins synchronous to mclk; strobes one cycle per access
// Notes: media engine drives busy/ready and error events
`timescale 1ns/1ps
module tfr_task_file
   import tfr_pkg::*;
(
   input wire logic mclk, // 250 MHz core clock
   input wire logic rstn, // async reset, active low
   input wire tfr_mode_e mode, // card access mode
   input wire logic [3:0] addr, // register offset
   input wire logic attribute_select_n, // 0 io, 1 memory
   input wire logic low_byte_enable_n, // even lane enable
   input wire logic high_byte_enable_n, // odd lane enable
   input wire logic block0_select_n, // ide command block
   input wire logic block1_select_n, // ide control block
   input wire logic dmack_n, // ide dma acknowledge
   input wire logic rd_stb, // host read strobe, 1 cycle
   input wire logic wr_stb, // host write strobe, 1 cycle
   input wire logic [15:0] wdata, // host write data
   output logic [15:0] rdata, // host read data, registered
   output logic [15:0] rdata_oe, // per line drive enable
   input wire logic pio8_enable, // 8-bit pio selected
   input wire logic card_number, // copy field number
   output logic [7:0] command_code, // last command
   output logic command_stb, // command accepted pulse
   output logic [7:0] feature_select, // feature register
   output logic [27:0] block_address, // linear address
   output logic linear_mode, // linear addressing on
   output logic [8:0] sectors_requested, // 1..256
   input wire tfr_stat_s stat, // engine status
   input wire tfr_err_ev_s err_ev, // error events
   input wire logic cmd_fail, // command ended in error
   input wire logic sector_done, // one sector finished
   input wire logic cmd_done, // command finished ok
   input wire logic [27:0] fail_address, // first bad sector
   input wire logic fail_load, // load failing address
   input wire logic dma_cmd, // dma command in data phase
   input wire logic dma_want, // engine wants dma word
   output logic dmarq, // dma request
   output logic intrq, // pending interrupt
   input wire logic int_event, // engine raises interrupt
   output logic [15:0] buf_wdata, // word to buffer
   output logic buf_wr, // buffer write pulse
   input wire logic [15:0] buf_rdata, // word from buffer
   output logic buf_rd // buffer read pulse
);
   logic [7:0] error_cause_r; // error causes
   logic [7:0] feature_r; // feature register
   logic [7:0] count_r; // transfer count
   logic [7:0] addr_lo_r; // start address low
   logic [7:0] addr_mid_r; // start address mid
   logic [7:0] addr_hi_r; // start address high
   logic [7:0] unit_r; // unit and top address
   logic [7:0] cmd_r; // command code
   logic cmd_stb_r; // command pulse
   logic cmd_err_r; // command error flag
   logic corrected_flag_r; // corrected flag
   logic int_r; // interrupt pending
   logic [7:0] even_hold_r; // byte pair assembly
   logic byte_phase_r; // next byte is odd
   logic [7:0] state_flags; // assembled status
   logic selected; // this card addressed
   logic ide_dma; // ide dma cycle
   logic ide_pio; // ide task file cycle
   logic pc_word; // pc card word access
   logic odd_only; // odd lane only access
   logic even_only; // even lane only access
   logic [3:0] reg_ofs; // effective offset
   logic data_sel; // data port hit
   logic err_sel; // error/feature hit
   logic new_cmd; // command write accepted
   logic host_wr; // register write allowed

   // access classification per mode
   always_comb
   begin
      ide_dma = (mode == TFR_MODE_IDE) && !dmack_n
         && block0_select_n && block1_select_n;
      ide_pio = (mode == TFR_MODE_IDE) && dmack_n
         && block1_select_n && !block0_select_n;
      pc_word = (mode != TFR_MODE_IDE) && !low_byte_enable_n
         && !high_byte_enable_n;
      odd_only = (mode != TFR_MODE_IDE) && low_byte_enable_n
         && !high_byte_enable_n;
      even_only = (mode != TFR_MODE_IDE) && !low_byte_enable_n
         && high_byte_enable_n;
      reg_ofs = addr;
      if (mode == TFR_MODE_IDE && !block1_select_n && block0_select_n
         && dmack_n)
      begin
         reg_ofs = (addr[2:0] == OFS_UNIT[2:0]) ? OFS_ALT : OFS_NONE;
      end
      else if (ide_pio)
      begin
         reg_ofs = {1'b0, addr[2:0]};
      end
      else if (mode == TFR_MODE_IDE)
      begin
         reg_ofs = OFS_NONE; // no chip select: no register hit
      end
   end

   // data port and error/feature lane decode
   always_comb
   begin
      data_sel = 1'b0;
      err_sel = 1'b0;
      if (ide_dma)
      begin
         data_sel = 1'b1;
      end
      else if (ide_pio && reg_ofs == OFS_DATA)
      begin
         data_sel = 1'b1;
      end
      else if (ide_pio && reg_ofs == OFS_ERR)
      begin
         err_sel = 1'b1;
      end
      else if (mode != TFR_MODE_IDE && odd_only
         && (reg_ofs == OFS_DATA || reg_ofs == OFS_ERR))
      begin
         err_sel = 1'b1;
      end
      else if (mode != TFR_MODE_IDE && pc_word
         && reg_ofs == OFS_DUP_ERR)
      begin
         err_sel = 1'b1;
      end
      else if (mode != TFR_MODE_IDE && (reg_ofs == OFS_DATA
         || reg_ofs == OFS_DUP_EVEN || reg_ofs == OFS_DUP_ODD))
      begin
         data_sel = 1'b1;
      end
      else if (mode != TFR_MODE_IDE && even_only
         && reg_ofs == OFS_DUP_ERR)
      begin
         err_sel = 1'b1;
      end
      else if (even_only && reg_ofs == OFS_ERR)
      begin
         err_sel = 1'b1;
      end
   end

   // card select and write lock while busy
   assign selected = (unit_r[UH_UNIT] == card_number);
   assign host_wr = wr_stb && !stat.busy && selected;
   assign new_cmd = host_wr && !data_sel && !err_sel
      && reg_ofs == OFS_STATUS;

   // status byte, busy hides all other flags
   always_comb
   begin
      state_flags = ZERO8;
      state_flags[ST_BUSY] = stat.busy;
      if (!stat.busy)
      begin
         state_flags[ST_RDY] = stat.ready;
         state_flags[ST_DWF] = stat.write_fault;
         state_flags[ST_DSC] = stat.seek_complete;
         state_flags[ST_DRQ] = stat.xfer_req;
         state_flags[ST_CORRECTED_FLAG] = corrected_flag_r;
         state_flags[ST_ERR] = cmd_err_r;
      end
   end

   // error causes: set wins over clear on new command
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         error_cause_r <= ZERO8;
         cmd_err_r <= 1'b0;
      end
      else
      begin
         if (new_cmd)
         begin
            error_cause_r <= ZERO8;
            cmd_err_r <= 1'b0;
         end
         if (err_ev.bad_block_or_crc)
            error_cause_r[ERR_BBK] <= 1'b1;
         if (err_ev.uncorrectable)
            error_cause_r[ERR_UNC] <= 1'b1;
         if (err_ev.sector_not_found)
            error_cause_r[ERR_SECTOR_NOT_FOUND_FLAG] <= 1'b1;
         if (err_ev.aborted)
            error_cause_r[ERR_ABORTED_FLAG] <= 1'b1;
         if (err_ev.general_error)
            error_cause_r[ERR_GEN] <= 1'b1;
         if (cmd_fail)
            cmd_err_r <= 1'b1;
      end
   end

   // corrected flag: cleared by new command, read goes on
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         corrected_flag_r <= 1'b0;
      else if (stat.corrected)
         corrected_flag_r <= 1'b1;
      else if (new_cmd)
         corrected_flag_r <= 1'b0;
   end

   // feature register, written through odd lane too
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         feature_r <= ZERO8;
      else if (host_wr && err_sel && (odd_only || pc_word))
         feature_r <= wdata[15:8];
      else if (host_wr && err_sel)
         feature_r <= wdata[7:0];
   end

   // command block registers; engine updates on progress/fail
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         count_r <= COUNT_ONE;
         addr_lo_r <= ZERO8;
         addr_mid_r <= ZERO8;
         addr_hi_r <= ZERO8;
         unit_r <= UNIT_RST;
      end
      else if (fail_load)
      begin
         addr_lo_r <= fail_address[7:0];
         addr_mid_r <= fail_address[15:8];
         addr_hi_r <= fail_address[23:16];
         unit_r[3:0] <= fail_address[27:24];
         // last sector still counted when the failure lands with it
         if (sector_done)
            count_r <= count_r - COUNT_ONE;
      end
      else if (cmd_done)
         count_r <= ZERO8;
      else if (sector_done)
         count_r <= count_r - COUNT_ONE;
      else if (host_wr && !data_sel && !err_sel)
      begin
         if (reg_ofs == OFS_COUNT)
            count_r <= wdata[7:0];
         else if (reg_ofs == OFS_ADDR_LO)
            addr_lo_r <= wdata[7:0];
         else if (reg_ofs == OFS_ADDR_MID)
            addr_mid_r <= wdata[7:0];
         else if (reg_ofs == OFS_ADDR_HI)
            addr_hi_r <= wdata[7:0];
         else if (reg_ofs == OFS_UNIT)
            unit_r <= wdata[7:0];
      end
   end

   // command code capture
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cmd_r <= ZERO8;
         cmd_stb_r <= 1'b0;
      end
      else
      begin
         cmd_stb_r <= new_cmd;
         if (new_cmd)
            cmd_r <= wdata[7:0];
      end
   end

   // interrupt: status read clears, mirror read does not
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         int_r <= 1'b0;
      else if (int_event)
         int_r <= 1'b1;
      else if (rd_stb && selected && !data_sel && !err_sel
         && reg_ofs == OFS_STATUS)
         int_r <= 1'b0;
   end

   // byte pairing of even-lane data accesses
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         even_hold_r <= ZERO8;
         byte_phase_r <= 1'b0;
      end
      else if (data_sel && even_only && (rd_stb || host_wr))
      begin
         byte_phase_r <= !byte_phase_r;
         if (!byte_phase_r)
            even_hold_r <= rd_stb ? buf_rdata[15:8] : wdata[7:0];
      end
      else if (new_cmd)
         byte_phase_r <= 1'b0;
   end

   // buffer strobes: word, single 8-bit pio byte, or byte pair (read on its first byte, write on its second)
   always_comb
   begin
      buf_rd = 1'b0;
      buf_wr = 1'b0;
      buf_wdata = wdata;
      if (data_sel && selected)
      begin
         if (ide_pio && pio8_enable)
         begin
            buf_rd = rd_stb;
            buf_wr = host_wr;
            buf_wdata = {ZERO8, wdata[7:0]};
         end
         else if (even_only || odd_only)
         begin
            buf_rd = rd_stb && !byte_phase_r;
            buf_wr = host_wr && byte_phase_r;
            buf_wdata = {wdata[7:0], even_hold_r};
         end
         else
         begin
            buf_rd = rd_stb;
            buf_wr = ide_dma ? wr_stb : host_wr;
         end
      end
   end

   // registered read data and lane enables
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdata <= ZERO16;
         rdata_oe <= ZERO16;
      end
      else if (!rd_stb || !(selected || ide_dma))
      begin
         rdata_oe <= ZERO16;
      end
      else if (data_sel)
      begin
         if (ide_pio && pio8_enable)
         begin
            rdata <= {ZERO8, buf_rdata[7:0]};
            rdata_oe <= {ZERO8, 8'hFF};
         end
         else if (even_only)
         begin
            rdata <= {ZERO8, byte_phase_r ? even_hold_r
               : buf_rdata[7:0]};
            rdata_oe <= {ZERO8, 8'hFF};
         end
         else
         begin
            rdata <= buf_rdata;
            rdata_oe <= 16'hFFFF;
         end
      end
      else if (err_sel && (odd_only || pc_word))
      begin
         rdata <= {error_cause_r, ZERO8};
         rdata_oe <= {8'hFF, ZERO8};
      end
      else
      begin
         rdata_oe <= {ZERO8, 8'hFF};
         if (err_sel)
            rdata <= {ZERO8, error_cause_r};
         else if (reg_ofs == OFS_COUNT)
            rdata <= {ZERO8, count_r};
         else if (reg_ofs == OFS_ADDR_LO)
            rdata <= {ZERO8, addr_lo_r};
         else if (reg_ofs == OFS_ADDR_MID)
            rdata <= {ZERO8, addr_mid_r};
         else if (reg_ofs == OFS_ADDR_HI)
            rdata <= {ZERO8, addr_hi_r};
         else if (reg_ofs == OFS_UNIT)
            rdata <= {ZERO8, unit_r};
         else if (reg_ofs == OFS_STATUS || reg_ofs == OFS_ALT)
            rdata <= {ZERO8, state_flags};
         else
            rdata <= ZERO16;
      end
   end

   // derived outputs
   assign linear_mode = unit_r[UH_LBA];
   assign block_address = {unit_r[3:0], addr_hi_r, addr_mid_r,
      addr_lo_r};
   assign sectors_requested = (count_r == ZERO8) ? COUNT_256
      : {1'b0, count_r};
   assign dmarq = dma_cmd && dma_want
      && (stat.busy || stat.xfer_req);
   assign intrq = int_r;
   assign command_code = cmd_r;
   assign command_stb = cmd_stb_r;
   assign feature_select = feature_r;
endmodule : tfr_task_file

/* tb/tfr_task_file_properties.sv */
// Purpose: port checker for the task file register block
// Assumes: one clock domain, host strobes one cycle wide
// Notes: bound onto every task file instance
`timescale 1ns/1ps
module tfr_task_file_chk
   import tfr_pkg::*;
(
   input wire logic mclk, // core clock
   input wire logic rstn, // async reset, active low
   input wire tfr_mode_e mode, // card access mode
   input wire logic [3:0] addr, // register offset
   input wire logic low_byte_enable_n, // even lane
   input wire logic high_byte_enable_n, // odd lane
   input wire logic block0_select_n, // command block
   input wire logic block1_select_n, // control block
   input wire logic rd_stb, // read strobe
   input wire logic wr_stb, // write strobe
   input wire logic [15:0] rdata, // read data
   input wire logic [15:0] rdata_oe, // read drive enable
   input wire logic command_stb, // command accepted
   input wire tfr_stat_s stat, // engine status
   input wire logic dmarq, // dma request
   input wire logic intrq, // pending interrupt
   input wire logic int_event, // interrupt event
   input wire logic buf_rd // buffer read pulse
);
   // card modes, byte registers on the host side
   wire pc = mode != TFR_MODE_IDE;
   // status read in either bus family
   wire st_rd = rd_stb && addr == OFS_STATUS &&
      (pc || (!block0_select_n && block1_select_n));
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   AST_BUF_RD: assert property (buf_rd |-> rd_stb)
      else $error("buffer read without host read");
   AST_OE_AFTER_RD: assert property (|rdata_oe |-> $past(rd_stb))
      else $error("data lines driven without a read");
   AST_CMD_TAKE: assert property (command_stb |-> $past(wr_stb) &&
      $past(addr) == OFS_STATUS && !$past(stat.busy))
      else $error("command taken without idle write");
   AST_BUSY_HIDE: assert property (st_rd && stat.busy |=>
      !rdata_oe[0] || rdata[7:0] == 8'h80)
      else $error("busy status shows other flags");
   AST_DMARQ_GATE: assert property (dmarq |-> stat.busy || stat.xfer_req)
      else $error("dma request while idle");
   AST_INT_CLR: assert property (st_rd && !int_event |=>
      !intrq || rdata_oe == 16'h0000)
      else $error("status read left interrupt");
   AST_ALT_KEEP: assert property (rd_stb && pc && addr == OFS_ALT &&
      intrq |=> intrq)
      else $error("mirror read cleared interrupt");
   AST_INT_SET: assert property (int_event |=> intrq)
      else $error("interrupt event lost");
   AST_IDX_ZERO: assert property (st_rd |=> !rdata_oe[1] || !rdata[1])
      else $error("index flag not zero");
   AST_ODD_LANE: assert property (rd_stb && pc && addr == OFS_DATA &&
      !high_byte_enable_n && low_byte_enable_n |=> rdata_oe[7:0] == 8'h00)
      else $error("odd lane read drove even lines");
   AST_ERR_ZERO: assert property (rd_stb && pc && addr == OFS_ERR &&
      !low_byte_enable_n && high_byte_enable_n |=>
      !rdata_oe[0] || (rdata[5] | rdata[3] | rdata[1]) == 1'h0)
      else $error("reserved error bits set");
   // main scenarios reached
   cover property (command_stb);
   cover property (st_rd && stat.busy);
   cover property (dmarq);
endmodule : tfr_task_file_chk
bind tfr_task_file tfr_task_file_chk chk (.mclk, .rstn, .mode, .addr,
   .low_byte_enable_n, .high_byte_enable_n, .block0_select_n,
   .block1_select_n, .rd_stb, .wr_stb, .rdata, .rdata_oe, .command_stb,
   .stat, .dmarq, .intrq, .int_event, .buf_rd);

/* tb/tfr_host_model.sv */
// Purpose: host adapter model driving the task file pins
// Assumes: one strobe cycle per access, answer one cycle later
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module tfr_host_model
   import tfr_pkg::*;
(
   input wire logic mclk, // core clock
   input wire tfr_mode_e mode, // card access mode
   input wire logic [15:0] rdata, // read data
   input wire logic [15:0] rdata_oe, // read drive enable
   output logic [3:0] addr = 4'h0, // register offset
   output logic attribute_select_n = 1'h1, // io or memory
   output logic low_byte_enable_n = 1'h1, // even lane
   output logic high_byte_enable_n = 1'h1, // odd lane
   output logic block0_select_n = 1'h1, // command block
   output logic block1_select_n = 1'h1, // control block
   output logic dmack_n = 1'h1, // dma acknowledge
   output logic rd_stb = 1'h0, // read strobe
   output logic wr_stb = 1'h0, // write strobe
   output logic [15:0] wdata = 16'h0000 // write data
);
   // one access: drive after an edge, take answer one edge later
   task automatic acc(input logic we, input logic dma,
      input logic [3:0] a, input logic [1:0] ben_n,
      input logic [15:0] d, output logic [15:0] q, output logic [15:0] oe);
      @(posedge mclk);
      #1;
      addr = a;
      {high_byte_enable_n, low_byte_enable_n} = ben_n;
      attribute_select_n = mode == TFR_MODE_MEM;
      block0_select_n = dma || a[3];
      block1_select_n = !(a[3] && !dma); // control block above 7
      dmack_n = !dma;
      wdata = d;
      wr_stb = we;
      rd_stb = !we;
      @(posedge mclk);
      #1;
      q = rdata;
      oe = rdata_oe;
      wr_stb = 1'h0;
      rd_stb = 1'h0;
      // released bus, stale values inverted
      addr = ~a;
      wdata = ~d;
      {high_byte_enable_n, low_byte_enable_n} = 2'h3;
      block0_select_n = 1'h1;
      block1_select_n = 1'h1;
      dmack_n = 1'h1;
   endtask : acc
endmodule : tfr_host_model

/* tb/tfr_task_file_test.sv */
// Purpose: directed register tests of the task file block
// Assumes: host model on the pins, engine inputs driven here
// Notes: inputs change one ns after the rising edge
`timescale 1ns/1ps
module tfr_task_file_test;
   import tfr_pkg::*;
   logic mclk = 1'h0, rstn = 1'h0; // clock, reset
   tfr_mode_e mode = TFR_MODE_MEM; // access mode
   logic pio8_enable = 1'h0, card_number = 1'h0; // card setup
   tfr_stat_s stat = '0; // engine status
   tfr_err_ev_s err_ev = '0; // error events
   logic cmd_fail = 1'h0, cmd_done = 1'h0, int_event = 1'h0; // events
   logic sector_done = 1'h0, fail_load = 1'h0; // progress events
   logic [27:0] fail_address = 28'h1ABCDEF; // failing sector
   logic dma_cmd = 1'h0, dma_want = 1'h0; // dma phase
   logic [15:0] buf_rdata = 16'hC3A5; // buffer word
   logic [15:0] rdata, rdata_oe, buf_wdata, wdata, rv, ov, last_bw;
   logic [7:0] command_code, feature_select; // outputs
   logic [27:0] block_address; // linear address
   logic [8:0] sectors_requested; // decoded count
   logic [3:0] addr; // host offset
   logic command_stb, linear_mode, dmarq, intrq, buf_wr, buf_rd;
   logic attribute_select_n, low_byte_enable_n, high_byte_enable_n;
   logic block0_select_n, block1_select_n, dmack_n, rd_stb, wr_stb;
   logic [7:0] epos [5] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h01};
   int miscompares = 0, samples_checked = 0; // tallies
   always #2 mclk = ~mclk;
   // capture buffer writes for comparison
   always @(posedge mclk)
      if (buf_wr) last_bw <= buf_wdata;
   tfr_task_file uut (.mclk, .rstn, .mode, .addr, .attribute_select_n,
      .low_byte_enable_n, .high_byte_enable_n, .block0_select_n,
      .block1_select_n, .dmack_n, .rd_stb, .wr_stb, .wdata, .rdata,
      .rdata_oe, .pio8_enable, .card_number, .command_code, .command_stb,
      .feature_select, .block_address, .linear_mode, .sectors_requested,
      .stat, .err_ev, .cmd_fail, .sector_done, .cmd_done,
      .fail_address, .fail_load, .dma_cmd, .dma_want,
      .dmarq, .intrq, .int_event, .buf_wdata, .buf_wr, .buf_rdata, .buf_rd);
   tfr_host_model host (.mclk, .mode, .rdata, .rdata_oe, .addr,
      .attribute_select_n, .low_byte_enable_n, .high_byte_enable_n,
      .block0_select_n, .block1_select_n, .dmack_n, .rd_stb, .wr_stb,
      .wdata);
   // compare one value and tally
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   task step;
      @(posedge mclk);
      #1;
   endtask : step
   // byte register access on the even lane
   task wr(input logic [3:0] a, input logic [7:0] d);
      host.acc(1'h1, 1'h0, a, 2'h2, {8'h00, d}, rv, ov);
   endtask : wr
   task rd(input logic [3:0] a);
      host.acc(1'h0, 1'h0, a, 2'h2, 16'h0000, rv, ov);
   endtask : rd
   task rdchk(input logic [3:0] a, input logic [7:0] e);
      rd(a);
      check(rv[7:0], e);
   endtask : rdchk
   // verdict and end of run
   task wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // watchdog against a hang
   initial
   begin
      repeat (4000) @(posedge mclk);
      miscompares++;
      wrap_up;
   end
   // main sequence
   initial
   begin
      repeat (2) @(posedge mclk);
      #1;
      rstn = 1'h1;
      rdchk(OFS_UNIT, UNIT_RST);
      rdchk(OFS_COUNT, COUNT_ONE);
      rdchk(OFS_STATUS, 8'h00);
      stat.ready = 1'h1;
      stat.seek_complete = 1'h1;
      rdchk(OFS_STATUS, 8'h50);
      rdchk(OFS_ALT, 8'h50);
      wr(OFS_ADDR_LO, 8'h12);
      wr(OFS_ADDR_MID, 8'h34);
      wr(OFS_ADDR_HI, 8'h56);
      wr(OFS_UNIT, 8'hE7);
      check({4'h0, block_address}, 32'h07563412);
      check(linear_mode, 1'h1);
      rdchk(OFS_ADDR_MID, 8'h34);
      wr(OFS_UNIT, 8'hA7);
      check(linear_mode, 1'h0);
      wr(OFS_COUNT, 8'h00);
      check(sectors_requested, 9'h100);
      wr(OFS_COUNT, 8'h03);
      wr(OFS_STATUS, 8'h20);
      step;
      cmd_done = 1'h1;
      step;
      cmd_done = 1'h0;
      rdchk(OFS_COUNT, 8'h00);
      // failure in the same cycle as a finished sector
      wr(OFS_COUNT, 8'h03);
      wr(OFS_STATUS, 8'h20);
      check(command_code, 8'h20);
      step;
      sector_done = 1'h1;
      fail_load = 1'h1;
      cmd_fail = 1'h1;
      step;
      sector_done = 1'h0;
      fail_load = 1'h0;
      cmd_fail = 1'h0;
      rdchk(OFS_COUNT, 8'h02);
      check({4'h0, block_address}, 32'h01ABCDEF);
      // each error cause after a failed command
      for (int i = 0; i < 5; i++)
      begin
         wr(OFS_STATUS, 8'h20);
         step;
         err_ev = tfr_err_ev_s'(5'h10 >> i);
         cmd_fail = 1'h1;
         step;
         err_ev = '0;
         cmd_fail = 1'h0;
         rdchk(OFS_ERR, epos[i]);
         rdchk(OFS_STATUS, 8'h51);
      end
      host.acc(1'h0, 1'h0, OFS_DATA, 2'h1, 16'h0000, rv, ov);
      check(rv[15:8], 8'h01);
      check(ov, 16'hFF00);
      host.acc(1'h1, 1'h0, OFS_DATA, 2'h1, 16'h5A00, rv, ov);
      check(feature_select, 8'h5A);
      wr(OFS_STATUS, 8'h20);
      rdchk(OFS_ERR, 8'h00);
      rdchk(OFS_STATUS, 8'h50);
      step;
      stat.corrected = 1'h1;
      step;
      stat.corrected = 1'h0;
      rdchk(OFS_STATUS, 8'h54);
      wr(OFS_STATUS, 8'h20);
      // host locked out while busy
      stat.busy = 1'h1;
      wr(OFS_ADDR_LO, 8'hFF);
      rdchk(OFS_STATUS, 8'h80);
      stat.busy = 1'h0;
      rdchk(OFS_ADDR_LO, 8'hEF);
      card_number = 1'h1;
      rd(OFS_STATUS);
      check(ov, 16'h0000);
      card_number = 1'h0;
      rd(OFS_STATUS);
      check(ov, 16'h00FF);
      // interrupt set, mirror read, status read
      int_event = 1'h1;
      step;
      int_event = 1'h0;
      check(intrq, 1'h1);
      rd(OFS_ALT);
      check(intrq, 1'h1);
      rd(OFS_STATUS);
      check(intrq, 1'h0);
      // data port words and one 8-bit pio byte
      host.acc(1'h1, 1'h0, OFS_DATA, 2'h0, 16'hBEEF, rv, ov);
      check(last_bw, 16'hBEEF);
      host.acc(1'h0, 1'h0, OFS_DATA, 2'h0, 16'h0000, rv, ov);
      check(rv, 16'hC3A5);
      check(ov, 16'hFFFF);
      mode = TFR_MODE_IDE;
      host.acc(1'h0, 1'h0, OFS_DATA, 2'h3, 16'h0000, rv, ov);
      check(ov, 16'hFFFF);
      host.acc(1'h0, 1'h1, 4'hF, 2'h3, 16'h0000, rv, ov);
      check({ov, rv}, 32'hFFFFC3A5);
      pio8_enable = 1'h1;
      host.acc(1'h0, 1'h0, OFS_DATA, 2'h3, 16'h0000, rv, ov);
      check(ov, 16'h00FF);
      pio8_enable = 1'h0;
      // dma request follows the transfer flag
      dma_cmd = 1'h1;
      dma_want = 1'h1;
      stat.xfer_req = 1'h1;
      step;
      check(dmarq, 1'h1);
      rdchk(OFS_STATUS, 8'h58);
      rdchk(OFS_ALT, 8'h58);
      stat.xfer_req = 1'h0;
      step;
      check(dmarq, 1'h0);
      dma_cmd = 1'h0;
      wrap_up;
   end
endmodule : tfr_task_file_test
